// ==== verilog/tw_core.sv ====
/*
 * Two-wire bus controller, master or slave, with plain control ports.
 * Assumes open-drain pads outside: a pin is pulled low while its enable
 * is high, and the bus lines arrive unsynchronised.
 */
`default_nettype none

// Functional notes
// - Bus mode works only while the interface mode field holds 10.
// - At each data-bit clock rise as master transmitter, mismatch between driven and line data sets lost flag.
// - Losing arbitration clears master and transmitter, stops clock generation.
// - After losing arbitration both clock and data pins are released.
// - Arbitration checks continue on every word, not only the first.
// - Lost flag clears on data write, data read or control B write.
// - Slave address mode: match flag on own address or general call.
// - Free format: match flag sets once the first word completes.
// - Match flag clears on any data write or data read.
// - General call flag on eight zero bits after start; start or stop clears.
// - Last-bit flag holds data line at each clock rise, showing acknowledge.
// - Start request with bus free issues start, then shifts out address byte.
// - Ninth falling edge raises interrupt, clears pending, holds clock low.
// - Transmitter select follows sent direction bit only if acknowledged.
// - Transmitter: data write sets pending and clocks out the next word.
// - Receiver: data read sets pending; device acknowledges by driving low.
// - Data read right after an address byte is not received data.
// - Ack mode cleared means no acknowledge clock for following word.
// - Count 001 read with ack mode cleared clocks one bit with data high as not-acknowledge.
// - Data access sets pending; software may set, never clear it.
// - Busy flag sets on start condition and clears on stop condition.
// - Stop request: master, transmitter, pending one with busy zero.
module tw_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic dat_wr_i,
  input wire logic [7:0] dat_wdata_i,
  input wire logic dat_rd_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic cra_wr_i,
  input wire tw_pkg::tw_cra_type cra_i,
  input wire logic oar_wr_i,
  input wire tw_pkg::tw_oar_type oar_i,
  input wire logic crb_wr_i,
  input wire tw_pkg::tw_crb_type crb_i,
  output var tw_pkg::tw_srb_type status_o,
  output logic bus_event_irq_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  tw_pkg::tw_cra_type cra_r;
  tw_pkg::tw_oar_type oar_r;
  tw_pkg::tw_mst_type st_r;
  logic [1:0] mode_r;
  logic mst_r, trx_r, bb_r, pin_r, al_r, aas_r, ad0_r, lrb_r, irq_r;
  logic [2:0] scl_s_r, sda_s_r;
  logic scl_f_r, sda_f_r;
  logic [15:0] tmr_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic act_r, first_r, stop_req_r;
  logic sda_oe_r, scl_oe_r, sda_o_r, scl_o_r;

  // ****************************************************************
  // Line filtering and bus conditions
  // ****************************************************************
  wire en = mode_r == tw_pkg::MODE_BUS;
  // Glitch filter: a level counts only once two late stages agree
  wire scl_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[1] : scl_f_r;
  wire sda_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[1] : sda_f_r;
  wire scl_rise = en & scl_nxt & ~scl_f_r;
  wire scl_fall = en & ~scl_nxt & scl_f_r;
  wire scl_hi = scl_f_r & scl_nxt;
  wire start_det = en & scl_hi & sda_f_r & ~sda_nxt;
  wire stop_det = en & scl_hi & ~sda_f_r & sda_nxt;

  // ****************************************************************
  // Word framing
  // ****************************************************************
  wire has_ack = cra_r.ack_mode;
  wire [3:0] nbits = (cra_r.word_bit_count == tw_pkg::BC_FULL) ?
                     tw_pkg::WORD_BITS : {1'b0, cra_r.word_bit_count};
  wire [3:0] last_slot = has_ack ? nbits : nbits - 4'h1;
  wire in_data = cnt_r < nbits;
  wire in_ack = has_ack & (cnt_r == nbits);
  wire word_end = scl_fall & act_r & (cnt_r == last_slot);
  wire [7:0] rx_byte = has_ack ? sh_r : {sh_r[6:0], lrb_r};
  wire [7:0] addr_byte = {sh_r[6:0], lrb_r};
  wire addr_done = scl_fall & act_r & first_r & ~mst_r & (cnt_r == tw_pkg::ADDR_LAST_BIT);
  wire own_hit = addr_byte[7:1] == oar_r.own_address_field;
  wire gc_hit = addr_byte == tw_pkg::GEN_CALL;
  wire addr_hit = ~oar_r.free_format_select & (own_hit | gc_hit);
  wire ff_hit = word_end & first_r & ~mst_r & oar_r.free_format_select;
  wire word_irq = word_end & (mst_r | aas_r | ff_hit);
  wire dat_acc = dat_wr_i | dat_rd_i;

  // ****************************************************************
  // Control requests
  // ****************************************************************
  wire start_go = en & crb_wr_i & crb_i.master_select & crb_i.transmitter_select &
                  crb_i.busy & crb_i.pending & ~bb_r;
  wire stop_go = crb_wr_i & crb_i.master_select & crb_i.transmitter_select &
                 ~crb_i.busy & crb_i.pending & bb_r;
  wire pin_set = dat_acc | (crb_wr_i & crb_i.pending);

  // ****************************************************************
  // Receive buffer
  // ****************************************************************
  wire buf_ready;
  // Only data words are stored, never the address byte
  wire rx_push = word_irq & ~trx_r & ~first_r;
  // Next receive word waits for room, stretching the clock
  wire rx_stall = ~trx_r & ~buf_ready & (cnt_r == tw_pkg::CNT_FIRST);

  tw_rx_buf u_rx_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push),
    .in_data_i(rx_byte),
    .in_ready_o(buf_ready),
    .out_ready_i(dat_rd_i),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o)
  );

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  wire lost = scl_rise & mst_r & trx_r & act_r & in_data & (sda_f_r != ~sda_oe_r);

  // ****************************************************************
  // Master clock generator
  // ****************************************************************
  wire [15:0] half = tw_pkg::HALF_CYC >> cra_r.rate;
  wire tmr_done = tmr_r == tw_pkg::TMR_RST;
  wire low_hold = ~pin_r | rx_stall;
  tw_pkg::tw_mst_type st_nxt;
  logic [15:0] tmr_nxt;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_done ? tmr_r : tmr_r - 16'h0001;
    case (st_r)
      tw_pkg::TW_IDLE: begin
        if (start_go) begin
          st_nxt = tw_pkg::TW_START;
          tmr_nxt = half;
        end
      end
      tw_pkg::TW_START: begin
        if (tmr_done) begin
          st_nxt = tw_pkg::TW_LOW;
          tmr_nxt = half;
        end
      end
      tw_pkg::TW_LOW: begin
        if (tmr_done && low_hold) begin
          tmr_nxt = half;
        end else if (tmr_done && stop_req_r) begin
          st_nxt = tw_pkg::TW_STOP;
          tmr_nxt = half;
        end else if (tmr_done) begin
          st_nxt = tw_pkg::TW_HIGH;
          tmr_nxt = half;
        end
      end
      tw_pkg::TW_HIGH: begin
        // Another master holding the line low delays our high phase
        if (!scl_f_r) begin
          tmr_nxt = half;
        end else if (tmr_done) begin
          st_nxt = tw_pkg::TW_LOW;
          tmr_nxt = half;
        end
      end
      tw_pkg::TW_STOP: begin
        if (tmr_done) begin
          st_nxt = tw_pkg::TW_STOPH;
          tmr_nxt = half;
        end
      end
      tw_pkg::TW_STOPH: begin
        if (!scl_f_r) begin
          tmr_nxt = half;
        end else if (tmr_done) begin
          st_nxt = tw_pkg::TW_IDLE;
        end
      end
      default: begin
        st_nxt = tw_pkg::TW_IDLE;
      end
    endcase
    if (lost || !en) begin
      st_nxt = tw_pkg::TW_IDLE;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  wire m_sda_force = (st_r == tw_pkg::TW_START) | (st_r == tw_pkg::TW_STOP) |
                     (st_r == tw_pkg::TW_STOPH) | (mst_r & act_r & (cnt_r == tw_pkg::CNT_PRE));
  wire want_ack = mst_r | aas_r | oar_r.free_format_select;
  wire d_lo = act_r & ((in_data & trx_r & ~sh_r[7]) | (in_ack & ~trx_r & want_ack));
  wire s_stretch = ~mst_r & aas_r & act_r & (cnt_r == tw_pkg::CNT_FIRST) & low_hold;
  wire m_scl_lo = (st_r == tw_pkg::TW_LOW) | (st_r == tw_pkg::TW_STOP);
  // After a loss the state leaves the drive states, so both pins float
  wire sda_oe_nxt = en & ~lost & ((st_nxt != tw_pkg::TW_IDLE & m_sda_force) | d_lo);
  wire scl_oe_nxt = en & ~lost & ((st_nxt == st_r & m_scl_lo) |
                    (st_nxt == tw_pkg::TW_LOW) | (st_nxt == tw_pkg::TW_STOP) | s_stretch);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= tw_pkg::TW_IDLE;
      tmr_r <= tw_pkg::TMR_RST;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_o_r <= 1'b0;
      scl_o_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      sda_oe_r <= sda_oe_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_o_r <= 1'b0;
      scl_o_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      scl_f_r <= scl_nxt;
      sda_f_r <= sda_nxt;
    end
  end

  // ****************************************************************
  // Bit counter and shifter
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= tw_pkg::CNT_PRE;
      act_r <= 1'b0;
      first_r <= 1'b0;
      sh_r <= 8'h00;
    end else begin
      if (start_det) begin
        cnt_r <= tw_pkg::CNT_PRE;
        act_r <= 1'b1;
        first_r <= 1'b1;
      end else if (stop_det || !en) begin
        act_r <= 1'b0;
      end else if (scl_fall && act_r) begin
        if (cnt_r == tw_pkg::CNT_PRE || cnt_r == last_slot) begin
          cnt_r <= tw_pkg::CNT_FIRST;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
        if (word_end) begin
          first_r <= 1'b0;
        end
      end
      if (dat_wr_i) begin
        sh_r <= dat_wdata_i;
      end else if (scl_fall && act_r && in_data) begin
        sh_r <= addr_byte;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cra_r <= tw_pkg::CRA_RST;
      oar_r <= tw_pkg::OAR_RST;
      mode_r <= tw_pkg::MODE_RST;
      stop_req_r <= 1'b0;
    end else begin
      if (cra_wr_i) begin
        cra_r <= cra_i;
      end
      // Address byte is always eight bits
      if (start_det) begin
        cra_r.word_bit_count <= tw_pkg::BC_FULL;
      end
      if (oar_wr_i) begin
        oar_r <= oar_i;
      end
      if (crb_wr_i) begin
        mode_r <= crb_i.interface_mode_select;
      end
      if (stop_go) begin
        stop_req_r <= 1'b1;
      end else if (stop_det || !mst_r) begin
        stop_req_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Mode bits
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mst_r <= 1'b0;
      trx_r <= 1'b0;
    end else begin
      if (crb_wr_i) begin
        mst_r <= crb_i.master_select;
        trx_r <= crb_i.transmitter_select;
      end
      if (word_end && mst_r && first_r && !lrb_r) begin
        trx_r <= ~sh_r[0];
      end
      if (addr_done && addr_hit && !gc_hit) begin
        trx_r <= addr_byte[0];
      end
      if (lost || stop_det) begin
        mst_r <= 1'b0;
      end
      if (lost) begin
        trx_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bb_r <= 1'b0;
      pin_r <= tw_pkg::PIN_RST;
      al_r <= 1'b0;
      aas_r <= 1'b0;
      ad0_r <= 1'b0;
      lrb_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (start_det) begin
        bb_r <= 1'b1;
      end else if (stop_det) begin
        bb_r <= 1'b0;
      end
      if (pin_set) begin
        pin_r <= 1'b1;
      end else if (word_irq) begin
        pin_r <= 1'b0;
      end
      if (lost) begin
        al_r <= 1'b1;
      end else if (dat_acc || crb_wr_i) begin
        al_r <= 1'b0;
      end
      if ((addr_done && addr_hit) || ff_hit) begin
        aas_r <= 1'b1;
      end else if (dat_acc) begin
        aas_r <= 1'b0;
      end
      if (addr_done && gc_hit) begin
        ad0_r <= 1'b1;
      end else if (start_det || stop_det) begin
        ad0_r <= 1'b0;
      end
      if (scl_rise) begin
        lrb_r <= sda_nxt;
      end
      irq_r <= word_irq;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign scl_o = scl_o_r;
  assign scl_oe_o = scl_oe_r;
  assign sda_o = sda_o_r;
  assign sda_oe_o = sda_oe_r;
  assign bus_event_irq_o = irq_r;
  assign status_o = {mst_r, trx_r, bb_r, pin_r, al_r, aas_r, ad0_r, lrb_r};

endmodule : tw_core

`default_nettype wire

// ==== verilog/tw_pkg.sv ====
/*
 * Shared constants, field layouts and state encodings of the two-wire
 * bus controller and its receive buffer.
 * Assumes a 50 MHz system clock; all users name items as tw_pkg::name.
 */
`default_nettype none

package tw_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 20;
  // Half bus-clock period at the slowest rate setting
  localparam int T_HALF_NS = 5000;
  localparam logic [15:0] HALF_CYC = 16'((T_HALF_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // Encodings and counts
  // ****************************************************************
  localparam logic [1:0] MODE_BUS = 2'b10;
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam logic [3:0] CNT_PRE = 4'hf;
  localparam logic [3:0] CNT_FIRST = 4'h0;
  localparam logic [2:0] BC_FULL = 3'h0;
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam int BUF_W = 8;
  localparam int BUF_D = 2;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic [2:0] word_bit_count;
    logic ack_mode;
    logic [2:0] rate;
  } tw_cra_type;

  typedef struct packed {
    logic [6:0] own_address_field;
    logic free_format_select;
  } tw_oar_type;

  typedef struct packed {
    logic master_select;
    logic transmitter_select;
    logic busy;
    logic pending;
    logic [1:0] interface_mode_select;
  } tw_crb_type;

  typedef struct packed {
    logic master_select;
    logic transmitter_select;
    logic bus_busy_flag;
    logic pending;
    logic lost_arbitration_flag;
    logic address_match_flag;
    logic general_call_flag;
    logic last_bit_flag;
  } tw_srb_type;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam tw_cra_type CRA_RST = 7'h00;
  localparam tw_oar_type OAR_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic PIN_RST = 1'b1;
  localparam logic [15:0] TMR_RST = 16'h0000;

  // ****************************************************************
  // Master clock generator states
  // ****************************************************************
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_START = 3'b001,
    TW_LOW = 3'b011,
    TW_HIGH = 3'b010,
    TW_STOP = 3'b110,
    TW_STOPH = 3'b111
  } tw_mst_type;

endpackage : tw_pkg

`default_nettype wire

// ==== verilog/tw_rx_buf.sv ====
/*
 * Small in-order buffer for received words, head entry kept in a flop.
 * Assumes one clock, push and pop qualified by valid and ready.
 */
`default_nettype none

module tw_rx_buf #(
  parameter int WIDTH = tw_pkg::BUF_W,
  parameter int DEPTH = tw_pkg::BUF_D
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic valid_r;
  logic [WIDTH-1:0] ent_w [DEPTH];

  wire push = in_valid_i & in_ready_o;
  wire pop = out_ready_i & valid_r;
  wire [CW-1:0] widx = pop ? cnt_r - CW'(1) : cnt_r;

  assign in_ready_o = cnt_r != CW'(DEPTH);
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign out_valid_o = valid_r;
  assign out_data_o = ent_w[0];

  // ****************************************************************
  // Entries shift toward the head on each pop
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic [WIDTH-1:0] ent_r;
    wire [WIDTH-1:0] below;
    if (i == DEPTH - 1) begin : g_last
      assign below = ent_r;
    end else begin : g_mid
      assign below = ent_w[i+1];
    end
    assign ent_w[i] = ent_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        ent_r <= '0;
      end else if (push && widx == CW'(i)) begin
        ent_r <= in_data_i;
      end else if (pop) begin
        ent_r <= below;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      valid_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      valid_r <= cnt_nxt != '0;
    end
  end

endmodule : tw_rx_buf

`default_nettype wire

// ==== tb/tw_core_assertions.sv ====
/* Port-level checks on the two-wire controller, bound to tw_core.
   Assumes one clock domain, clk_i rising, rst_i active high. */
`default_nettype none

module tw_core_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dat_wr_i,
  input wire logic dat_rd_i,
  input wire logic crb_wr_i,
  input wire tw_pkg::tw_crb_type crb_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire tw_pkg::tw_srb_type status_o,
  input wire logic bus_event_irq_o
);
  // ********************************
  // Control and bus relations
  // ********************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_pend; (dat_wr_i || dat_rd_i) |=> status_o.pending; endproperty
  a_pend: assert property (p_pend) else $error("pending not set by data access");
  property p_irq; bus_event_irq_o && status_o.master_select |-> ##[0:1] !status_o.pending;
  endproperty
  a_irq: assert property (p_irq) else $error("pending kept at word end");
  property p_hold; (status_o.master_select && !status_o.pending) [*2] |-> scl_oe_o; endproperty
  a_hold: assert property (p_hold) else $error("clock not held low");
  property p_lost; $rose(status_o.lost_arbitration_flag) |-> ##[0:1]
    !(status_o.master_select || status_o.transmitter_select); endproperty
  a_lost: assert property (p_lost) else $error("master kept after loss");
  property p_rel; $rose(status_o.lost_arbitration_flag) |-> ##[0:2]
    (!scl_oe_o && !sda_oe_o) [*4]; endproperty
  a_rel: assert property (p_rel) else $error("pins driven after loss");
  property p_alclr; (dat_wr_i || dat_rd_i || crb_wr_i) |=> !status_o.lost_arbitration_flag;
  endproperty
  a_alclr: assert property (p_alclr) else $error("lost flag not cleared");
  property p_aas; (dat_wr_i || dat_rd_i) |=> !status_o.address_match_flag; endproperty
  a_aas: assert property (p_aas) else $error("match flag not cleared");
  property p_gc; $fell(status_o.bus_busy_flag) |-> ##[0:1] !status_o.general_call_flag;
  endproperty
  a_gc: assert property (p_gc) else $error("general call kept past stop");
  property p_stp; $fell(status_o.bus_busy_flag) |-> ##[0:1] !status_o.master_select;
  endproperty
  a_stp: assert property (p_stp) else $error("master kept past stop");
  property p_start; crb_wr_i && crb_i == 6'h3e && !status_o.bus_busy_flag |->
    ##[1:3] sda_oe_o && !scl_oe_o; endproperty
  a_start: assert property (p_start) else $error("no start on request");
endmodule // tw_core_checker

bind tw_core tw_core_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .dat_wr_i(dat_wr_i), .dat_rd_i(dat_rd_i),
  .crb_wr_i(crb_wr_i), .crb_i(crb_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
  .status_o(status_o), .bus_event_irq_o(bus_event_irq_o)
);

`default_nettype wire

// ==== tb/tw_peer.sv ====
/* Bus slave model: acks address and written words, sends tx_byte_i on reads.
   Assumes wired-AND lines with pull-ups resolved by the bench. */
`default_nettype none

module tw_peer (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  input wire logic [7:0] tx_byte_i,
  output logic sda_oe_o,
  output logic [7:0] got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  logic rd = 1'b0;
  logic adr = 1'b0;
  initial sda_oe_o = 1'b0;
  initial got_o = 8'h00;
  // ********************************
  // Framing and slot drive
  // ********************************
  // Clock fall after a start is not a bit; it brings the count to zero
  always @(negedge sda_i) if (scl_i) begin
    n = -1;
    adr = 1'b1;
    rd = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) begin
    n = 0;
    sda_oe_o = 1'b0;
  end
  // Not-acknowledge from the master ends our transmit, like a real slave
  always @(posedge scl_i) if (n < 8) got_o = {got_o[6:0], sda_i};
    else if (sda_i && !adr) rd = 1'b0;
  always @(negedge scl_i) begin
    if (n == 8) begin
      n = 0;
      if (adr) rd = got_o[0];
      adr = 1'b0;
    end else n = n + 1;
    if (n == 8) sda_oe_o = !(rd && !adr) && ack_en_i;
    else sda_oe_o = rd && !adr && !tx_byte_i[7-n];
  end
endmodule // tw_peer

`default_nettype wire

// ==== tb/tw_core_bench.sv ====
/* Self-checking bench for tw_core with a bus slave model.
   Assumes open-drain pads modelled here as a wired AND with pull-ups. */
`default_nettype none

module tw_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DWR = 0, DRD = 1, OAR = 2, CRA = 3, CRB = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic p_scl = 1'b1;
  logic p_sda = 1'b1;
  logic ack_en = 1'b0;
  logic a;
  logic dat_wr_i = 1'b0, dat_rd_i = 1'b0, cra_wr_i = 1'b0, oar_wr_i = 1'b0, crb_wr_i = 1'b0;
  logic [7:0] dat_wdata_i = 8'h00;
  tw_pkg::tw_cra_type cra_i = 7'h00;
  tw_pkg::tw_oar_type oar_i = 8'h00;
  tw_pkg::tw_crb_type crb_i = 6'h00;
  tw_pkg::tw_srb_type st;
  logic scl_oe, sda_oe, peer_oe, irq, rdv;
  logic [1:0] so;
  logic [7:0] rdd, got;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  wire logic scl = !scl_oe && p_scl;
  wire logic sda = !sda_oe && !peer_oe && p_sda;

  tw_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .scl_o(so[1]), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(so[0]), .sda_oe_o(sda_oe), .dat_wr_i(dat_wr_i),
    .dat_wdata_i(dat_wdata_i),
    .dat_rd_i(dat_rd_i), .rd_data_o(rdd), .rd_valid_o(rdv), .cra_wr_i(cra_wr_i), .cra_i(cra_i),
    .oar_wr_i(oar_wr_i), .oar_i(oar_i), .crb_wr_i(crb_wr_i), .crb_i(crb_i), .status_o(st),
    .bus_event_irq_o(irq));
  tw_peer u_peer (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .tx_byte_i(8'h5a),
    .sda_oe_o(peer_oe), .got_o(got));

  always #10 clk_i = !clk_i;
  // Whole run is a few thousand cycles; the ceiling only cuts a hang
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ********************************
  // Access tasks
  // ********************************
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic put(input int k, input logic [7:0] v);
    w(1);
    dat_wdata_i = v;
    cra_i = v[6:0];
    oar_i = v;
    crb_i = v[5:0];
    {crb_wr_i, cra_wr_i, oar_wr_i, dat_rd_i, dat_wr_i} = 5'h01 << k;
    w(1);
    {crb_wr_i, cra_wr_i, oar_wr_i, dat_rd_i, dat_wr_i} = 5'h00;
  endtask
  task automatic wt(input int sel);
    for (int k = 0; k < 3000; k++) begin
      if (sel == 0 ? st.bus_busy_flag === 1'b0 : sel == 1 ? scl_oe === 1'b1 :
          sel == 2 ? st.lost_arbitration_flag === 1'b1 : irq === 1'b1) break;
      w(1);
    end
    w(2);
  endtask
  // Foreign master at a 160 ns bus clock; ninth slot left released
  // Long low phase: the slave's filtered answer needs about five cycles
  task automatic frame(input logic [7:0] b);
    p_sda = 1'b0;
    w(4);
    p_scl = 1'b0;
    for (int i = 7; i >= -1; i--) begin
      w(1);
      p_sda = (i < 0) ? 1'b1 : b[i];
      w(4);
      p_scl = 1'b1;
      w(2);
      a = sda;
      w(1);
      p_scl = 1'b0;
    end
  endtask
  task automatic stop_bus;
    p_sda = 1'b0;
    w(2);
    p_scl = 1'b1;
    w(24);
    p_sda = 1'b1;
    w(8);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    w(12);
    rst_i = 1'b0;
    w(1);
    chk("reset", st, 8'h10);
    frame(8'h00);
    chk("off_ack", {7'h00, a}, 8'h01);
    chk("off", st, 8'h10);
    stop_bus;
    put(CRA, 8'h0c);
    put(OAR, {7'h2a, 1'b0});
    put(CRB, 8'h06);
    frame({7'h2a, 1'b0});
    chk("ack", {7'h00, a}, 8'h00);
    wt(3);
    chk("match", st, 8'h24);
    put(DRD, 8'h00);
    chk("aas_clr", st, 8'h30);
    stop_bus;
    frame(8'h00);
    wt(3);
    chk("gcall", st, 8'h26);
    put(DRD, 8'h00);
    stop_bus;
    chk("gc_clr", st, 8'h10);
    put(OAR, {7'h2a, 1'b1});
    frame(8'h32);
    wt(3);
    chk("ff_match", st, 8'h24);
    put(DRD, 8'h00);
    stop_bus;
    put(OAR, {7'h2a, 1'b0});
    ack_en = 1'b1;
    put(DWR, {7'h50, 1'b0});
    put(CRB, 8'h3e);
    wt(3);
    chk("addr_w", st, 8'he0);
    put(DWR, 8'ha5);
    wt(3);
    chk("peer", got, 8'ha5);
    chk("lrb_w", st, 8'he0);
    put(CRB, 8'h36);
    wt(0);
    // Stop clears the master select and busy flag; transmitter keeps the written 1
    chk("stop_w", st, 8'h50);
    put(DWR, {7'h50, 1'b1});
    put(CRB, 8'h3e);
    wt(3);
    chk("addr_r", st, 8'ha0);
    put(DRD, 8'h00);
    wt(3);
    chk("rx1", st, 8'ha0);
    chk("rx1_d", rdv ? rdd : 8'hxx, 8'h5a);
    put(CRA, 8'h04);
    put(DRD, 8'h00);
    wt(3);
    chk("rx2_d", rdv ? rdd : 8'hxx, 8'h5a);
    put(CRA, 8'h14);
    put(DRD, 8'h00);
    wt(3);
    chk("nack", st, 8'ha1);
    put(CRB, 8'h36);
    wt(0);
    chk("stop_r", st, 8'h50);
    put(DWR, 8'hff);
    put(CRB, 8'h3e);
    wt(1);
    p_sda = 1'b0;
    wt(2);
    chk("arb", st & 8'hc8, 8'h08);
    chk("arb_pins", {6'h00, scl_oe, sda_oe}, 8'h00);
    put(CRB, 8'h06);
    chk("al_clr", st & 8'h08, 8'h00);
    p_sda = 1'b1;
    w(20);
    chk("arb_stop", st & 8'h20, 8'h00);
    chk("pin_lvl", {6'h00, so}, 8'h00);
    wrap_up();
  end
endmodule // tw_core_bench

`default_nettype wire
